// ### src/interrupt_vector_selector.sv
// Interrupt vector selector: vector slot address, table select and bit locations
`timescale 1ns/1ps

module ivs_interrupt_vector_selector #(
  parameter int NUM_SRC = 94
) (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         ctlWrite,
  input  wire logic [15:0]                  ctlWdata,
  output logic      [15:0]                  ctlRdata,
  input  wire logic                         reqValid,
  input  wire ivs_pkg::ivs_req_t            req,
  input  wire logic [NUM_SRC-1:0]           srcPending,
  output logic                              slotValid,
  output logic      [ivs_pkg::ADDR_W-1:0]   slotAddr,
  input  wire logic                         slotDataValid,
  input  wire logic [ivs_pkg::ADDR_W-1:0]   slotData,
  output logic                              jumpValid,
  output logic      [ivs_pkg::ADDR_W-1:0]   jumpAddr,
  output logic      [ivs_pkg::ADDR_W-1:0]   pcOut,
  output logic                              winValid,
  output logic      [ivs_pkg::VNUM_W-1:0]   winNum,
  output ivs_pkg::ivs_loc_t                 winLoc,
  output logic                              altTableSelect
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode functions

  // Primary slot of a trap or interrupt; alternate adds the fixed offset
  function automatic logic [23:0] slot_of(input ivs_pkg::ivs_req_t r, input logic alt);
    logic [23:0] base;
    logic [23:0] idx;
    base = r.isTrap ? ivs_pkg::TRAP_BASE : ivs_pkg::IRQ_BASE;
    idx  = r.isTrap ? {20'h00000, r.num[2:0], 1'b0} : {16'h0000, r.num, 1'b0};
    slot_of = base + idx + (alt ? ivs_pkg::ALT_OFFSET : ivs_pkg::ZERO_ADDR);
  endfunction

  // Register and bit positions of a source's flag, enable and priority
  function automatic ivs_pkg::ivs_loc_t loc_of(input logic [6:0] n);
    ivs_pkg::ivs_loc_t l;
    l.flagReg = n[6:4];
    l.flagBit = n[3:0];
    l.prioReg = n[6:2];
    l.prioLsb = {n[1:0], 2'b00};
    loc_of = l;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Control register two: only the table select bit is kept here

  logic altSel_ff;

  always_ff @(posedge clock)
  begin
    if (rst)
      altSel_ff <= ivs_pkg::SEL_RESET;
    else if (ctlWrite)
      altSel_ff <= ctlWdata[ivs_pkg::SEL_BIT_POS];
  end

  // Other bits of the register belong to neighbouring logic and read zero here
  always_comb
  begin
    ctlRdata = 16'h0000;
    ctlRdata[ivs_pkg::SEL_BIT_POS] = altSel_ff;
  end

  assign altTableSelect = altSel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch: request issues a slot read, returned word becomes the target

  logic                  slotValid_ff;
  logic [23:0]           slotAddr_ff;
  logic                  jumpValid_ff;
  logic [23:0]           jumpAddr_ff;
  logic [23:0]           pc_ff;
  logic                  busy_ff;

  // Select is sampled at request time, so a write mid-fetch cannot split tables
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      slotValid_ff <= 1'b0;
      slotAddr_ff  <= ivs_pkg::ZERO_ADDR;
      busy_ff      <= 1'b0;
    end
    else
    begin
      slotValid_ff <= reqValid && !busy_ff;
      if (reqValid && !busy_ff)
      begin
        slotAddr_ff <= slot_of(req, altSel_ff);
        busy_ff     <= 1'b1;
      end
      else if (slotDataValid)
        busy_ff <= 1'b0;
    end
  end

  // Slot contents are used whole as a 24-bit handler address
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      jumpValid_ff <= 1'b0;
      jumpAddr_ff  <= ivs_pkg::ZERO_ADDR;
    end
    else
    begin
      jumpValid_ff <= busy_ff && slotDataValid;
      if (busy_ff && slotDataValid)
        jumpAddr_ff <= slotData;
    end
  end

  // Program counter: zero at reset, then follows vector redirects
  always_ff @(posedge clock)
  begin
    if (rst)
      pc_ff <= ivs_pkg::RESET_ADDR;
    else if (busy_ff && slotDataValid)
      pc_ff <= slotData;
  end

  assign slotValid = slotValid_ff;
  assign slotAddr  = slotAddr_ff;
  assign jumpValid = jumpValid_ff;
  assign jumpAddr  = jumpAddr_ff;
  assign pcOut     = pc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Natural priority among equally ranked pending sources

  logic                  winValid_ff;
  logic [6:0]            winNum_ff;
  ivs_pkg::ivs_loc_t     winLoc_ff;
  logic                  anyPend;
  logic [6:0]            lowNum;

  // Scan from the top down so the lowest vector number is left standing
  always_comb
  begin
    anyPend = 1'b0;
    lowNum  = 7'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (srcPending[i])
      begin
        anyPend = 1'b1;
        lowNum  = 7'(i);
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      winValid_ff <= 1'b0;
      winNum_ff   <= 7'h00;
      winLoc_ff   <= '0;
    end
    else
    begin
      winValid_ff <= anyPend;
      winNum_ff   <= lowNum;
      winLoc_ff   <= loc_of(lowNum);
    end
  end

  assign winValid = winValid_ff;
  assign winNum   = winNum_ff;
  assign winLoc   = winLoc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_sel_reset;
    @(posedge clock) rst |=> !altTableSelect;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select not zero after reset");

  property p_sel_write;
    @(posedge clock) disable iff (rst)
      ctlWrite |=> altTableSelect == $past(ctlWdata[15]) && ctlRdata[15] == altTableSelect;
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select bit not written");

  property p_alt_offset;
    @(posedge clock) disable iff (rst)
      (reqValid && !busy_ff) |=>
        slotValid && slotAddr == $past(slot_of(req, 1'b0)) +
        ($past(altSel_ff) ? 24'h000100 : 24'h000000);
  endproperty
  a_alt_offset: assert property (p_alt_offset) else $error("alternate offset wrong");

  property p_alt_range;
    @(posedge clock) disable iff (rst)
      (slotValid && $past(altSel_ff)) |-> slotAddr >= 24'h000104 && slotAddr <= 24'h0001CE;
  endproperty
  a_alt_range: assert property (p_alt_range) else $error("alternate slot outside table");

  property p_trap_slot;
    @(posedge clock) disable iff (rst)
      (reqValid && !busy_ff && req.isTrap && !altSel_ff) |=>
        slotAddr == 24'h000004 + {20'h00000, $past(req.num[2:0]), 1'b0};
  endproperty
  a_trap_slot: assert property (p_trap_slot) else $error("trap slot wrong");

  property p_irq_slot;
    @(posedge clock) disable iff (rst)
      (reqValid && !busy_ff && !req.isTrap && !altSel_ff) |=>
        slotAddr == 24'h000014 + {16'h0000, $past(req.num), 1'b0};
  endproperty
  a_irq_slot: assert property (p_irq_slot) else $error("interrupt slot wrong");

  property p_reset_pc;
    @(posedge clock) rst |=> pcOut == 24'h000000 && !slotValid && !jumpValid;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("reset did not zero pc");

  property p_jump_data;
    @(posedge clock) disable iff (rst)
      (busy_ff && slotDataValid) |=> jumpValid && jumpAddr == $past(slotData) && pcOut == jumpAddr;
  endproperty
  a_jump_data: assert property (p_jump_data) else $error("handler address not taken");

  property p_natural;
    @(posedge clock) disable iff (rst)
      anyPend |=> winValid && winLoc.flagReg == winNum[6:4] && winLoc.prioReg == winNum[6:2] &&
        winLoc.prioLsb == {winNum[1:0], 2'b00};
  endproperty
  a_natural: assert property (p_natural) else $error("bit location wrong");

  // Registered copy of the pending vector, so the winner is judged against
  // what the scan saw and not against the scan's own result
  logic [NUM_SRC-1:0]    pendSeen_ff;
  logic [NUM_SRC-1:0]    belowWin;

  always_ff @(posedge clock)
  begin
    if (rst)
      pendSeen_ff <= '0;
    else
      pendSeen_ff <= srcPending;
  end

  // Pending sources below the reported winner; there must be none
  always_comb
  begin
    belowWin = pendSeen_ff & ((NUM_SRC'(1) << winNum) - NUM_SRC'(1));
  end

  property p_lowest;
    @(posedge clock) disable iff (rst)
      winValid |-> pendSeen_ff[winNum] && belowWin == '0;
  endproperty
  a_lowest: assert property (p_lowest) else $error("winner not lowest pending");

  property p_win_valid;
    @(posedge clock) disable iff (rst)
      winValid == (pendSeen_ff != '0);
  endproperty
  a_win_valid: assert property (p_win_valid) else $error("winner flag wrong");

  property p_trap_alt;
    @(posedge clock) disable iff (rst)
      (reqValid && !busy_ff && req.isTrap && altSel_ff) |=>
        slotAddr == 24'h000104 + {20'h00000, $past(req.num[2:0]), 1'b0};
  endproperty
  a_trap_alt: assert property (p_trap_alt) else $error("alternate trap slot wrong");

  property p_irq_alt;
    @(posedge clock) disable iff (rst)
      (reqValid && !busy_ff && !req.isTrap && altSel_ff) |=>
        slotAddr == 24'h000114 + {16'h0000, $past(req.num), 1'b0};
  endproperty
  a_irq_alt: assert property (p_irq_alt) else $error("alternate interrupt slot wrong");

  // A refused or absent request leaves the bus quiet and the last address alone
  property p_slot_hold;
    @(posedge clock) disable iff (rst)
      !(reqValid && !busy_ff) |=> !slotValid && $stable(slotAddr);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot read without request");

  // Outside a vector redirect the program counter model must not move
  property p_pc_hold;
    @(posedge clock) disable iff (rst)
      !(busy_ff && slotDataValid) |=> $stable(pcOut);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved without a vector");

endmodule

// ### src/ivs_pkg.sv
// Package for the interrupt vector selector: address map constants and carriers
package ivs_pkg;

  localparam int          ADDR_W         = 24;
  localparam int          VNUM_W         = 7;
  localparam int          TRAP_CNT       = 8;
  localparam int          MAX_VECTOR     = 93;
  localparam int          SEL_BIT_POS    = 15;
  localparam logic        SEL_RESET      = 1'b0;
  localparam logic [23:0] RESET_ADDR     = 24'h000000;
  localparam logic [23:0] TRAP_BASE      = 24'h000004;
  localparam logic [23:0] IRQ_BASE       = 24'h000014;
  localparam logic [23:0] ALT_OFFSET     = 24'h000100;
  localparam logic [23:0] ZERO_ADDR      = 24'h000000;
  localparam logic [2:0]  TRAP_OSC_FAIL  = 3'h1;
  localparam logic [2:0]  TRAP_ADDR_ERR  = 3'h2;
  localparam logic [2:0]  TRAP_STACK_ERR = 3'h3;
  localparam logic [2:0]  TRAP_MATH_ERR  = 3'h4;

  // Where a source's control bits live
  typedef struct packed {
    logic [2:0] flagReg;
    logic [3:0] flagBit;
    logic [4:0] prioReg;
    logic [3:0] prioLsb;
  } ivs_loc_t;

  // Vector request from the arbiter
  typedef struct packed {
    logic             isTrap;
    logic [VNUM_W-1:0] num;
  } ivs_req_t;

endpackage

// ### verification/interrupt_vector_selector_test.sv
// Self-checking testbench for the interrupt vector selector
`timescale 1ns/1ps
module interrupt_vector_selector_test;
  logic clock, rst, ctlWrite, reqValid, slotDataValid, slotValid, jumpValid;
  logic winValid, altTableSelect;
  logic [15:0] ctlWdata, ctlRdata;
  logic [93:0] srcPending;
  logic [23:0] slotAddr, slotData, jumpAddr, pcOut;
  logic [6:0]  winNum;
  logic [3:0]  latency;
  ivs_pkg::ivs_req_t req;
  ivs_pkg::ivs_loc_t winLoc;
  int mismatches = 0;
  int checks     = 0;
  ////////////////////////////////////////////////////////////////////////////////
  ivs_interrupt_vector_selector #(.NUM_SRC(94)) ivs_interrupt_vector_selector_i (
    .clock(clock), .rst(rst), .ctlWrite(ctlWrite), .ctlWdata(ctlWdata),
    .ctlRdata(ctlRdata), .reqValid(reqValid), .req(req), .srcPending(srcPending),
    .slotValid(slotValid), .slotAddr(slotAddr), .slotDataValid(slotDataValid),
    .slotData(slotData), .jumpValid(jumpValid), .jumpAddr(jumpAddr), .pcOut(pcOut),
    .winValid(winValid), .winNum(winNum), .winLoc(winLoc), .altTableSelect(altTableSelect));
  ivs_prog_mem_model ivs_prog_mem_model_i (
    .clock(clock), .rst(rst), .slotValid(slotValid), .slotAddr(slotAddr),
    .latency(latency), .slotDataValid(slotDataValid), .slotData(slotData));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One-cycle strobe on the control register, then read back the stored word
  task automatic write_ctl(input logic [15:0] d, input logic [15:0] exp);
    ctlWrite = 1'b1;
    ctlWdata = d;
    @(negedge clock);
    ctlWrite = 1'b0;
    @(negedge clock);
    check({8'h00, ctlRdata}, {8'h00, exp});
    check({23'h0, altTableSelect}, {23'h0, exp[15]});
  endtask
  // Request held one edge; slot read must follow and the jump carries its word
  task automatic fetch(input logic trap, input logic [6:0] n, input logic [23:0] exp);
    int k;
    logic [23:0] expJump;
    // Reserved traps 0, 5, 6 and 7 land on the shared default handler
    expJump = (trap && (n[2:0] == 3'h0 || n[2:0] > 3'h4)) ? 24'hC3FF00 : {16'hC300, exp[7:0]};
    req.isTrap = trap;
    req.num    = n;
    reqValid   = 1'b1;
    @(negedge clock);
    reqValid = 1'b0;
    check({23'h0, slotValid}, 24'h000001);
    check(slotAddr, exp);
    k = 0;
    while (jumpValid !== 1'b1 && k < 40)
    begin
      @(negedge clock);
      k++;
    end
    check({23'h0, jumpValid}, 24'h000001);
    check(jumpAddr, expJump);
    check(pcOut, expJump);
    @(negedge clock);
  endtask
  task automatic test_reset_state();
    check(pcOut, 24'h000000);
    check({23'h0, slotValid}, 24'h000000);
    check({8'h00, ctlRdata}, 24'h000000);
    $display("test_reset_state done");
  endtask
  task automatic test_tables(input logic alt);
    latency = alt ? 4'h6 : 4'h0;
    write_ctl(alt ? 16'hFFFF : 16'h7FFF, alt ? 16'h8000 : 16'h0000);
    for (int t = 0; t < 8; t++)
      fetch(1'b1, 7'(t), 24'h000004 + 24'(2 * t) + (alt ? 24'h000100 : 24'h0));
    fetch(1'b0, 7'h00, alt ? 24'h000114 : 24'h000014);
    fetch(1'b0, 7'h05, alt ? 24'h00011E : 24'h00001E);
    fetch(1'b0, 7'h5D, alt ? 24'h0001CE : 24'h0000CE);
    $display("test_tables done");
  endtask
  task automatic test_priority();
    srcPending = '0;
    srcPending[93] = 1'b1;
    srcPending[13] = 1'b1;
    repeat (2) @(negedge clock);
    check({17'h0, winNum}, 24'h00000D);
    check({23'h0, winValid}, 24'h000001);
    check({8'h00, winLoc}, {8'h00, 3'h0, 4'hD, 5'h03, 4'h4});
    srcPending[13] = 1'b0;
    repeat (2) @(negedge clock);
    check({17'h0, winNum}, 24'h00005D);
    check({8'h00, winLoc}, {8'h00, 3'h5, 4'hD, 5'h17, 4'h4});
    srcPending = '0;
    repeat (2) @(negedge clock);
    check({23'h0, winValid}, 24'h000000);
    $display("test_priority done");
  endtask
  task automatic test_mid_reset();
    write_ctl(16'h8000, 16'h8000);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check({23'h0, altTableSelect}, 24'h000000);
    check(pcOut, 24'h000000);
    check({23'h0, slotValid}, 24'h000000);
    $display("test_mid_reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held 20 cycles, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    ctlWrite = 1'b0;
    ctlWdata = 16'h0000;
    reqValid = 1'b0;
    req = '0;
    srcPending = '0;
    latency = 4'h0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    test_reset_state();
    test_tables(1'b0);
    test_tables(1'b1);
    test_priority();
    test_mid_reset();
    report_and_stop();
  end
  // Watchdog well past the expected few hundred cycles
  initial
  begin
    #80000;
    mismatches++;
    report_and_stop();
  end
endmodule

// ### verification/ivs_prog_mem_model.sv
// Program memory model that answers vector slot reads from the selector
`timescale 1ns/1ps
module ivs_prog_mem_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slotValid,
  input  wire logic [23:0] slotAddr,
  input  wire logic [3:0]  latency,
  output logic             slotDataValid,
  output logic      [23:0] slotData
);
  logic        busy;
  logic [3:0]  waitCnt;
  logic [23:0] lastData;
  ////////////////////////////////////////////////////////////////////////////////
  // Answer after latency cycles; both tables hold the same handlers, and the
  // reserved trap slots all point at one shared default handler
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      busy          <= 1'b0;
      waitCnt       <= 4'h0;
      slotDataValid <= 1'b0;
      lastData      <= 24'h000000;
    end
    else if (slotValid)
    begin
      busy          <= 1'b1;
      waitCnt       <= latency;
      slotDataValid <= 1'b0;
    end
    else if (busy && waitCnt == 4'h0)
    begin
      busy          <= 1'b0;
      slotDataValid <= 1'b1;
      lastData      <= (slotAddr[7:0] == 8'h04 || (slotAddr[7:0] > 8'h0D && slotAddr[7:0] < 8'h14))
                       ? 24'hC3FF00 : {16'hC300, slotAddr[7:0]};
    end
    else
    begin
      waitCnt       <= busy ? waitCnt - 4'h1 : waitCnt;
      slotDataValid <= 1'b0;
    end
  end
  // Outside the answer cycle show the inverse so a stale read cannot pass
  assign slotData = slotDataValid ? lastData : ~lastData;
endmodule
